// ==== fod_params.svh ====
// fod_params.svh: opcode values, field positions and clock counts of the
// floating point opcode decoder, as `define macros.
// assumes: included by bare name from the package and the decoder module.
//
// Notes on behaviour
// - stack pointer increment: no data, two clocks
// - push register or memory real, two clocks
// - decimal load converts and pushes, 41-45 clocks
// - integer loads push: 4-8, 4-6, 3-6 clocks
// - push one, pi or zero in four clocks
// - push log constants in four clocks each
// - control word load from memory, four clocks
// - multiply, register form: direction bit picks destination, 4-9 clocks; memory form 4-8 or 4-6
// - multiply into ST(n) then pop, 4-9 clocks
// - integer multiply: 9-11 or 8-10 clocks
// - arctangent into ST(1), pop, 97-161 clocks
// - both remainder forms take 82-91 clocks
// - tangent then push one, 117-129 clocks
// - round stack top in place, 10-20 clocks
// - state restore takes 56-72 clocks
// - save: waiting 57-67, plain 55-65 clocks
// - scale by power of two, 7-14 clocks
// - sine replaces stack top, 76-140 clocks
// - sine/cosine: sine in top, push cosine
// - square root replaces stack top, 59-60 clocks
// - store without pop to ST(n)/memory, two clocks
`ifndef FOD_PARAMS_SVH
`define FOD_PARAMS_SVH

// ==========================================================
// escape opcodes and fixed second bytes
`define FOD_ESC_D8 8'hd8
`define FOD_ESC_D9 8'hd9
`define FOD_ESC_DA 8'hda
`define FOD_ESC_DB 8'hdb
`define FOD_ESC_DC 8'hdc
`define FOD_ESC_DD 8'hdd
`define FOD_ESC_DE 8'hde
`define FOD_ESC_DF 8'hdf
`define FOD_B2_INC 8'hf7
`define FOD_B2_ONE 8'he8
`define FOD_B2_L2T 8'he9
`define FOD_B2_L2E 8'hea
`define FOD_B2_PI 8'heb
`define FOD_B2_LG2 8'hec
`define FOD_B2_LN2 8'hed
`define FOD_B2_ZERO 8'hee
`define FOD_B2_ATAN 8'hf3
`define FOD_B2_PREM 8'hf8
`define FOD_B2_PREM1 8'hf5
`define FOD_B2_TAN 8'hf2
`define FOD_B2_RND 8'hfc
`define FOD_B2_SCALE 8'hfd
`define FOD_B2_SIN 8'hfe
`define FOD_B2_SINCOS 8'hfb
`define FOD_B2_SQRT 8'hfa
// register-form upper five bits of the modrm byte
`define FOD_RF_PUSH 5'h18
`define FOD_RF_MUL 5'h19
`define FOD_RF_STORE 5'h1a
`define FOD_MOD_REG 2'h3
// ==========================================================
// clock counts, min and max
`define FOD_T_TWO 8'h02
`define FOD_T_FOUR 8'h04
`define FOD_T_BCD_MIN 8'h29
`define FOD_T_BCD_MAX 8'h2d
`define FOD_T_I64_MAX 8'h08
`define FOD_T_I32_MAX 8'h06
`define FOD_T_I16_MIN 8'h03
`define FOD_T_MUL_MAX 8'h09
`define FOD_T_IM32_MIN 8'h09
`define FOD_T_IM32_MAX 8'h0b
`define FOD_T_IM16_MIN 8'h08
`define FOD_T_IM16_MAX 8'h0a
`define FOD_T_ATAN_MIN 8'h61
`define FOD_T_ATAN_MAX 8'ha1
`define FOD_T_REM_MIN 8'h52
`define FOD_T_REM_MAX 8'h5b
`define FOD_T_TAN_MIN 8'h75
`define FOD_T_TAN_MAX 8'h81
`define FOD_T_RND_MIN 8'h0a
`define FOD_T_RND_MAX 8'h14
`define FOD_T_RST_MIN 8'h38
`define FOD_T_RST_MAX 8'h48
`define FOD_T_SAVW_MIN 8'h39
`define FOD_T_SAVW_MAX 8'h43
`define FOD_T_SAVN_MIN 8'h37
`define FOD_T_SAVN_MAX 8'h41
`define FOD_T_SCL_MIN 8'h07
`define FOD_T_SCL_MAX 8'h0e
`define FOD_T_SIN_MIN 8'h4c
`define FOD_T_SIN_MAX 8'h8c
`define FOD_T_SC_MIN 8'h91
`define FOD_T_SC_MAX 8'ha1
`define FOD_T_SQRT_MIN 8'h3b
`define FOD_T_SQRT_MAX 8'h3c
// reset values
`define FOD_CW_RESET 16'h037f
`define FOD_TOP_RESET 3'h0

`endif

// ==== fod_pkg.sv ====
// fod_pkg.sv: types shared by the floating point opcode decoder.
// assumes: fod_params.svh sits in the same folder.
`default_nettype none

package fod_pkg;
  `include "fod_params.svh"

  // ==========================================================
  // decoded operation classes
  typedef enum logic [4:0] {
    OP_NONE = 5'h00, OP_INC = 5'h01, OP_PUSH_REG = 5'h02, OP_PUSH_MEM = 5'h03,
    OP_DEC_LOAD = 5'h04, OP_INT_LOAD = 5'h05, OP_CONST = 5'h06, OP_CW_LOAD = 5'h07,
    OP_MUL = 5'h08, OP_MUL_POP = 5'h09, OP_INT_MUL = 5'h0a, OP_ATAN = 5'h0b,
    OP_REM = 5'h0c, OP_TAN = 5'h0d, OP_ROUND = 5'h0e, OP_RESTORE = 5'h0f,
    OP_SAVE = 5'h10, OP_SCALE = 5'h11, OP_SINE = 5'h12, OP_SINCOS = 5'h13,
    OP_SQRT = 5'h14, OP_STORE = 5'h15
  } fod_op_type;

  // constant selector for load-constant pushes
  typedef enum logic [2:0] {
    CK_ONE = 3'h0, CK_PI = 3'h1, CK_ZERO = 3'h2, CK_L2E = 3'h3,
    CK_L2T = 3'h4, CK_LG2 = 3'h5, CK_LN2 = 3'h6
  } fod_const_type;

  // controller states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_WAIT = 2'h1, ST_RUN = 2'h2
  } fod_state_type;

  // one decoded instruction
  typedef struct packed {
    logic valid;
    fod_op_type op;
    logic [7:0] min_clk;
    logic [7:0] max_clk;
    logic push;
    logic pop;
    logic inc;
    logic mem;
    logic dest_stn;
    logic [2:0] reg_idx;
    fod_const_type konst;
  } fod_dec_type;
endpackage : fod_pkg

`default_nettype wire

// ==== fod_decoder.sv ====
// fod_decoder.sv: decodes one floating point opcode, runs its clock count,
// and applies its stack-pointer effect and control-word load when done.
// assumes: the integer pipeline offers an opcode pair with a one-cycle
// issue strobe only while ready is high, sharing the core clock and reset.
`default_nettype none
`include "fod_params.svh"

module fod_decoder
  import fod_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic ISSUE_IN,
  input wire logic WAIT_PREFIX_IN,
  input wire logic [7:0] OPCODE_IN,
  input wire logic [7:0] MODRM_IN,
  input wire logic SLOW_IN,
  input wire logic PEND_EXC_IN,
  input wire logic [15:0] CW_DATA_IN,
  output logic READY_OUT,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic ILLEGAL_OUT,
  output logic EXC_REQ_OUT,
  output logic [4:0] OP_CLASS_OUT,
  output logic PUSH_OUT,
  output logic POP_OUT,
  output logic MEM_OUT,
  output logic DEST_STN_OUT,
  output logic [2:0] REG_IDX_OUT,
  output logic [2:0] CONST_SEL_OUT,
  output logic [2:0] STACK_TOP_OUT,
  output logic [15:0] CTRL_WORD_OUT
);

  // ==========================================================
  // decode function
  function automatic fod_dec_type decode(input logic [7:0] opc, input logic [7:0] mrm,
                                         input logic wt);
    fod_dec_type d;
    logic rf;
    logic [2:0] rg;
    d = '0;
    d.op = OP_NONE;
    d.konst = CK_ONE;
    rf = (mrm[7:6] == `FOD_MOD_REG);
    rg = mrm[5:3];
    d.reg_idx = mrm[2:0];
    d.mem = !rf;
    d.valid = 1'b1;
    // default to the two-clock figure; branches with longer counts override
    d.min_clk = `FOD_T_TWO;
    d.max_clk = `FOD_T_TWO;
    case (opc)
      `FOD_ESC_D9: begin
        if (rf && mrm[7:3] == `FOD_RF_PUSH) begin
          d.op = OP_PUSH_REG; d.push = 1'b1;
        end else if (!rf && rg == 3'h0) begin
          d.op = OP_PUSH_MEM; d.push = 1'b1;
        end else if (!rf && rg == 3'h5) begin
          d.op = OP_CW_LOAD; d.min_clk = `FOD_T_FOUR; d.max_clk = `FOD_T_FOUR;
        end else if (!rf && rg == 3'h2) begin
          d.op = OP_STORE;
        end else begin
          d.min_clk = `FOD_T_FOUR;
          d.max_clk = `FOD_T_FOUR;
          case (mrm)
            `FOD_B2_INC: begin
              d.op = OP_INC; d.inc = 1'b1;
              d.min_clk = `FOD_T_TWO; d.max_clk = `FOD_T_TWO;
            end
            `FOD_B2_ONE: begin d.op = OP_CONST; d.push = 1'b1; d.konst = CK_ONE; end
            `FOD_B2_PI: begin d.op = OP_CONST; d.push = 1'b1; d.konst = CK_PI; end
            `FOD_B2_ZERO: begin d.op = OP_CONST; d.push = 1'b1; d.konst = CK_ZERO; end
            `FOD_B2_L2E: begin d.op = OP_CONST; d.push = 1'b1; d.konst = CK_L2E; end
            `FOD_B2_L2T: begin d.op = OP_CONST; d.push = 1'b1; d.konst = CK_L2T; end
            `FOD_B2_LG2: begin d.op = OP_CONST; d.push = 1'b1; d.konst = CK_LG2; end
            `FOD_B2_LN2: begin d.op = OP_CONST; d.push = 1'b1; d.konst = CK_LN2; end
            `FOD_B2_ATAN: begin
              d.op = OP_ATAN; d.pop = 1'b1;
              d.min_clk = `FOD_T_ATAN_MIN; d.max_clk = `FOD_T_ATAN_MAX;
            end
            `FOD_B2_PREM, `FOD_B2_PREM1: begin
              d.op = OP_REM;
              d.min_clk = `FOD_T_REM_MIN; d.max_clk = `FOD_T_REM_MAX;
            end
            `FOD_B2_TAN: begin
              d.op = OP_TAN; d.push = 1'b1;
              d.min_clk = `FOD_T_TAN_MIN; d.max_clk = `FOD_T_TAN_MAX;
            end
            `FOD_B2_RND: begin
              d.op = OP_ROUND;
              d.min_clk = `FOD_T_RND_MIN; d.max_clk = `FOD_T_RND_MAX;
            end
            `FOD_B2_SCALE: begin
              d.op = OP_SCALE;
              d.min_clk = `FOD_T_SCL_MIN; d.max_clk = `FOD_T_SCL_MAX;
            end
            `FOD_B2_SIN: begin
              d.op = OP_SINE;
              d.min_clk = `FOD_T_SIN_MIN; d.max_clk = `FOD_T_SIN_MAX;
            end
            `FOD_B2_SINCOS: begin
              d.op = OP_SINCOS; d.push = 1'b1;
              d.min_clk = `FOD_T_SC_MIN; d.max_clk = `FOD_T_SC_MAX;
            end
            `FOD_B2_SQRT: begin
              d.op = OP_SQRT;
              d.min_clk = `FOD_T_SQRT_MIN; d.max_clk = `FOD_T_SQRT_MAX;
            end
            default: d.valid = 1'b0;
          endcase
        end
      end
      `FOD_ESC_DD: begin
        if (rf && mrm[7:3] == `FOD_RF_STORE) begin
          d.op = OP_STORE; d.dest_stn = 1'b1;
        end else if (!rf && rg == 3'h0) begin
          d.op = OP_PUSH_MEM; d.push = 1'b1;
        end else if (!rf && rg == 3'h2) begin
          d.op = OP_STORE;
        end else if (!rf && rg == 3'h4) begin
          d.op = OP_RESTORE;
          d.min_clk = `FOD_T_RST_MIN; d.max_clk = `FOD_T_RST_MAX;
        end else if (!rf && rg == 3'h6) begin
          d.op = OP_SAVE;
          d.min_clk = wt ? `FOD_T_SAVW_MIN : `FOD_T_SAVN_MIN;
          d.max_clk = wt ? `FOD_T_SAVW_MAX : `FOD_T_SAVN_MAX;
        end else begin
          d.valid = 1'b0;
        end
      end
      `FOD_ESC_DB: begin
        if (!rf && rg == 3'h0) begin
          d.op = OP_INT_LOAD; d.push = 1'b1;
          d.min_clk = `FOD_T_FOUR; d.max_clk = `FOD_T_I32_MAX;
        end else if (!rf && rg == 3'h5) begin
          d.op = OP_PUSH_MEM; d.push = 1'b1;
        end else begin
          d.valid = 1'b0;
        end
      end
      `FOD_ESC_DF: begin
        d.push = 1'b1;
        if (!rf && rg == 3'h4) begin
          d.op = OP_DEC_LOAD;
          d.min_clk = `FOD_T_BCD_MIN; d.max_clk = `FOD_T_BCD_MAX;
        end else if (!rf && rg == 3'h5) begin
          d.op = OP_INT_LOAD;
          d.min_clk = `FOD_T_FOUR; d.max_clk = `FOD_T_I64_MAX;
        end else if (!rf && rg == 3'h0) begin
          d.op = OP_INT_LOAD;
          d.min_clk = `FOD_T_I16_MIN; d.max_clk = `FOD_T_I32_MAX;
        end else begin
          d.valid = 1'b0;
        end
      end
      `FOD_ESC_DC, `FOD_ESC_D8: begin
        d.min_clk = `FOD_T_FOUR;
        if (rf && mrm[7:3] == `FOD_RF_MUL) begin
          d.op = OP_MUL; d.max_clk = `FOD_T_MUL_MAX;
          d.dest_stn = opc[2];
        end else if (!rf && rg == 3'h1) begin
          d.op = OP_MUL;
          d.max_clk = opc[2] ? `FOD_T_I64_MAX : `FOD_T_I32_MAX;
        end else begin
          d.valid = 1'b0;
        end
      end
      `FOD_ESC_DE: begin
        if (rf && mrm[7:3] == `FOD_RF_MUL) begin
          d.op = OP_MUL_POP; d.pop = 1'b1; d.dest_stn = 1'b1;
          d.min_clk = `FOD_T_FOUR; d.max_clk = `FOD_T_MUL_MAX;
        end else if (!rf && rg == 3'h1) begin
          d.op = OP_INT_MUL;
          d.min_clk = `FOD_T_IM16_MIN; d.max_clk = `FOD_T_IM16_MAX;
        end else begin
          d.valid = 1'b0;
        end
      end
      `FOD_ESC_DA: begin
        if (!rf && rg == 3'h1) begin
          d.op = OP_INT_MUL;
          d.min_clk = `FOD_T_IM32_MIN; d.max_clk = `FOD_T_IM32_MAX;
        end else begin
          d.valid = 1'b0;
        end
      end
      default: d.valid = 1'b0;
    endcase
    return d;
  endfunction : decode

  // ==========================================================
  // state
  fod_state_type state_q; // controller state
  fod_dec_type dec_d; // combinational decode of the offered opcode
  fod_dec_type cur_q; // instruction in flight
  logic [7:0] cnt_q; // clocks still to spend
  logic take; // accepted issue this cycle
  logic finish; // last clock of the instruction

  assign dec_d = decode(OPCODE_IN, MODRM_IN, WAIT_PREFIX_IN);
  assign take = ISSUE_IN && state_q == ST_IDLE && dec_d.valid;
  assign finish = state_q == ST_RUN && cnt_q == 8'h01;

  // ==========================================================
  // controller: idle, exception wait, run
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            // waiting form holds off while exceptions are pending
            state_q <= (WAIT_PREFIX_IN && PEND_EXC_IN) ? ST_WAIT : ST_RUN;
          end
        end
        ST_WAIT: if (!PEND_EXC_IN) state_q <= ST_RUN;
        ST_RUN: if (finish) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // latch decode and clock count on issue; count down while running
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cur_q <= '0;
      cnt_q <= 8'h00;
    end else if (take) begin
      cur_q <= dec_d;
      cnt_q <= SLOW_IN ? dec_d.max_clk : dec_d.min_clk;
    end else if (state_q == ST_RUN && cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // ==========================================================
  // stack pointer and control word, updated on completion
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      STACK_TOP_OUT <= `FOD_TOP_RESET;
    end else if (finish) begin
      if (cur_q.push) STACK_TOP_OUT <= STACK_TOP_OUT - 3'h1;
      else if (cur_q.pop || cur_q.inc) STACK_TOP_OUT <= STACK_TOP_OUT + 3'h1;
    end
  end

  // control word captured from the memory operand
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      CTRL_WORD_OUT <= `FOD_CW_RESET;
    end else if (finish && cur_q.op == OP_CW_LOAD) begin
      CTRL_WORD_OUT <= CW_DATA_IN;
    end
  end

  // ==========================================================
  // handshake and status outputs
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      READY_OUT <= 1'b1;
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      ILLEGAL_OUT <= 1'b0;
      EXC_REQ_OUT <= 1'b0;
    end else begin
      READY_OUT <= (state_q == ST_IDLE && !take) || finish;
      BUSY_OUT <= take || (state_q != ST_IDLE && !finish);
      DONE_OUT <= finish;
      ILLEGAL_OUT <= ISSUE_IN && state_q == ST_IDLE && !dec_d.valid;
      // ask the core to resolve pending exceptions before starting
      EXC_REQ_OUT <= (take && WAIT_PREFIX_IN && PEND_EXC_IN)
                     || (state_q == ST_WAIT && PEND_EXC_IN);
    end
  end

  // decoded attributes of the instruction in flight
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      OP_CLASS_OUT <= 5'h00;
      PUSH_OUT <= 1'b0;
      POP_OUT <= 1'b0;
      MEM_OUT <= 1'b0;
      DEST_STN_OUT <= 1'b0;
      REG_IDX_OUT <= 3'h0;
      CONST_SEL_OUT <= 3'h0;
    end else if (take) begin
      OP_CLASS_OUT <= dec_d.op;
      PUSH_OUT <= dec_d.push;
      POP_OUT <= dec_d.pop;
      MEM_OUT <= dec_d.mem;
      DEST_STN_OUT <= dec_d.dest_stn;
      REG_IDX_OUT <= dec_d.reg_idx;
      CONST_SEL_OUT <= dec_d.konst;
    end
  end

endmodule : fod_decoder

`default_nettype wire

// ==== fod_decoder_chk.sv ====
// fod_decoder_chk.sv: timing and stack-effect checks for the opcode decoder.
// assumes: sees only the decoder's ports; one clock, reset active low.
`default_nettype none

module fod_decoder_chk
  import fod_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic ISSUE_IN,
  input wire logic WAIT_PREFIX_IN,
  input wire logic [7:0] OPCODE_IN,
  input wire logic [7:0] MODRM_IN,
  input wire logic SLOW_IN,
  input wire logic PEND_EXC_IN,
  input wire logic [15:0] CW_DATA_IN,
  input wire logic READY_OUT,
  input wire logic BUSY_OUT,
  input wire logic DONE_OUT,
  input wire logic ILLEGAL_OUT,
  input wire logic EXC_REQ_OUT,
  input wire logic [4:0] OP_CLASS_OUT,
  input wire logic PUSH_OUT,
  input wire logic POP_OUT,
  input wire logic MEM_OUT,
  input wire logic DEST_STN_OUT,
  input wire logic [2:0] REG_IDX_OUT,
  input wire logic [2:0] CONST_SEL_OUT,
  input wire logic [2:0] STACK_TOP_OUT,
  input wire logic [15:0] CTRL_WORD_OUT
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  logic take; // plain issue accepted
  logic d9; // plain issue of the d9 group
  logic mem_op; // memory form of the modrm byte
  logic [2:0] idx_in; // register index field
  logic dir_in; // direction bit of the escape byte
  assign take = ISSUE_IN && READY_OUT && !WAIT_PREFIX_IN;
  assign d9 = take && (OPCODE_IN == 8'hd9);
  assign mem_op = (MODRM_IN[7:6] != 2'h3);
  assign idx_in = MODRM_IN[2:0];
  assign dir_in = OPCODE_IN[2];

  // ==========================================================
  // assertions
  inc_two_clk_a: assert property (d9 && MODRM_IN == 8'hf7 |=> BUSY_OUT[*2] ##1
    (DONE_OUT && STACK_TOP_OUT == 3'($past(STACK_TOP_OUT, 3) + 3'h1)))
    else $error("increment timing or pointer wrong");
  const_push_a: assert property (d9 && MODRM_IN >= 8'he8 && MODRM_IN <= 8'hee |=>
    BUSY_OUT[*4] ##1 (DONE_OUT && STACK_TOP_OUT == 3'($past(STACK_TOP_OUT, 5) - 3'h1)))
    else $error("constant push wrong");
  cw_load_a: assert property (d9 && mem_op && MODRM_IN[5:3] == 3'h5 |->
    ##5 (DONE_OUT && CTRL_WORD_OUT == $past(CW_DATA_IN))) else $error("control word load wrong");
  dec_load_a: assert property (take && OPCODE_IN == 8'hdf && mem_op &&
    MODRM_IN[5:3] == 3'h4 && SLOW_IN |-> ##45 !DONE_OUT ##1 DONE_OUT)
    else $error("decimal load timing wrong");
  sqrt_time_a: assert property (d9 && MODRM_IN == 8'hfa && !SLOW_IN |=>
    BUSY_OUT[*8] ##51 (BUSY_OUT && !DONE_OUT) ##1 DONE_OUT) else $error("root timing wrong");
  mul_pop_a: assert property (take && OPCODE_IN == 8'hde && MODRM_IN[7:3] == 5'h19 |=>
    (POP_OUT && !PUSH_OUT && OP_CLASS_OUT == OP_MUL_POP && REG_IDX_OUT == $past(idx_in)))
    else $error("multiply pop attributes wrong");
  mul_dir_a: assert property (take && (OPCODE_IN == 8'hdc || OPCODE_IN == 8'hd8) &&
    MODRM_IN[7:3] == 5'h19 |=> DEST_STN_OUT == $past(dir_in)) else $error("direction wrong");
  store_keep_a: assert property (take && OPCODE_IN == 8'hdd && MODRM_IN[7:3] == 5'h1a |=>
    BUSY_OUT ##1 BUSY_OUT ##1 (DONE_OUT && STACK_TOP_OUT == $past(STACK_TOP_OUT, 3)))
    else $error("store changed pointer");
  exc_hold_a: assert property (ISSUE_IN && READY_OUT && WAIT_PREFIX_IN && PEND_EXC_IN &&
    OPCODE_IN == 8'hdd && mem_op && MODRM_IN[5:3] == 3'h6 |=>
    (EXC_REQ_OUT && BUSY_OUT && !DONE_OUT)) else $error("exception hold missing");
  illegal_pulse_a: assert property (take && OPCODE_IN == 8'h00 |=>
    (ILLEGAL_OUT && READY_OUT && !BUSY_OUT)) else $error("illegal opcode not flagged");

  // ==========================================================
  // covers
  cover property (d9 && MODRM_IN == 8'hf7);
  cover property (EXC_REQ_OUT ##1 !EXC_REQ_OUT);
  cover property (DONE_OUT ##1 BUSY_OUT);
endmodule : fod_decoder_chk

bind fod_decoder fod_decoder_chk u_chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
  .ISSUE_IN(ISSUE_IN), .WAIT_PREFIX_IN(WAIT_PREFIX_IN), .OPCODE_IN(OPCODE_IN),
  .MODRM_IN(MODRM_IN), .SLOW_IN(SLOW_IN), .PEND_EXC_IN(PEND_EXC_IN), .CW_DATA_IN(CW_DATA_IN),
  .READY_OUT(READY_OUT), .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT), .ILLEGAL_OUT(ILLEGAL_OUT),
  .EXC_REQ_OUT(EXC_REQ_OUT), .OP_CLASS_OUT(OP_CLASS_OUT), .PUSH_OUT(PUSH_OUT),
  .POP_OUT(POP_OUT), .MEM_OUT(MEM_OUT), .DEST_STN_OUT(DEST_STN_OUT),
  .REG_IDX_OUT(REG_IDX_OUT), .CONST_SEL_OUT(CONST_SEL_OUT),
  .STACK_TOP_OUT(STACK_TOP_OUT), .CTRL_WORD_OUT(CTRL_WORD_OUT));

`default_nettype wire

// ==== fod_pipe_model.sv ====
// fod_pipe_model.sv: integer pipeline side that offers opcodes to the decoder.
// assumes: the caller enters issue just after a rising edge.
`default_nettype none

module fod_pipe_model (
  input wire logic clk_in,
  input wire logic ready_in,
  output logic issue_out,
  output logic wait_out,
  output logic [7:0] opcode_out,
  output logic [7:0] modrm_out,
  output logic slow_out
);
  // ==========================================================
  // idle lines at time zero
  initial begin
    issue_out = 1'b0;
    wait_out = 1'b0;
    opcode_out = 8'h00;
    modrm_out = 8'h00;
    slow_out = 1'b0;
  end

  // ==========================================================
  // one-cycle offer once the decoder is ready, or after 400 cycles without ready
  task automatic issue(input logic [7:0] op, input logic [7:0] mr, input logic wp,
                       input logic sl);
    int n;
    n = 0;
    while (ready_in !== 1'b1 && n < 400) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    issue_out = 1'b1;
    wait_out = wp;
    opcode_out = op;
    modrm_out = mr;
    slow_out = sl;
    @(posedge clk_in);
    #1;
    // released lines show garbage, not the last value
    issue_out = 1'b0;
    wait_out = ~wp;
    opcode_out = ~op;
    modrm_out = ~mr;
    slow_out = ~sl;
  endtask : issue
endmodule : fod_pipe_model

`default_nettype wire

// ==== tb_top.sv ====
// tb_top.sv: self-checking bench for the opcode decoder.
// assumes: decoder, package, checker and pipeline model compiled before.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic pend = 1'b0;
  logic [15:0] cw = 16'h0000;
  wire logic issue, wp, slow, ready, busy, done, illegal, exc, push, pop, mem, dest;
  wire logic [7:0] op, mr;
  wire logic [4:0] cls;
  wire logic [2:0] idx, ksel, top;
  wire logic [15:0] ctrl;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  fod_pipe_model u_pipe (.clk_in(clk), .ready_in(ready), .issue_out(issue), .wait_out(wp),
    .opcode_out(op), .modrm_out(mr), .slow_out(slow));
  fod_decoder u_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .ISSUE_IN(issue), .WAIT_PREFIX_IN(wp),
    .OPCODE_IN(op), .MODRM_IN(mr), .SLOW_IN(slow), .PEND_EXC_IN(pend), .CW_DATA_IN(cw),
    .READY_OUT(ready), .BUSY_OUT(busy), .DONE_OUT(done), .ILLEGAL_OUT(illegal),
    .EXC_REQ_OUT(exc), .OP_CLASS_OUT(cls), .PUSH_OUT(push), .POP_OUT(pop), .MEM_OUT(mem),
    .DEST_STN_OUT(dest), .REG_IDX_OUT(idx), .CONST_SEL_OUT(ksel), .STACK_TOP_OUT(top),
    .CTRL_WORD_OUT(ctrl));

  // ==========================================================
  // verdict and compare
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // issue, hold pending exception for hold cycles, count cycles to done
  task automatic run(input logic [7:0] o, input logic [7:0] m, input logic w, input logic s,
                     input int hold, input int ncyc, input logic [2:0] dtop);
    int k;
    logic [2:0] t0;
    t0 = top;
    pend = (hold > 0);
    u_pipe.issue(o, m, w, s);
    k = 1;
    while (done !== 1'b1 && k < 400) begin
      @(posedge clk);
      #1;
      k++;
      pend = (k <= hold);
    end
    chk(16'(k), 16'(ncyc));
    chk({13'h0, top}, {13'h0, 3'(t0 + dtop)});
  endtask : run

  // ==========================================================
  // scenarios
  task automatic t_loads;
    run(8'hd9, 8'hf7, 0, 0, 0, 3, 3'h1);
    run(8'hd9, 8'hc3, 0, 0, 0, 3, 3'h7);
    chk({15'h0, mem}, 16'h0000);
    run(8'hdd, 8'h00, 0, 1, 0, 3, 3'h7);
    chk({15'h0, mem}, 16'h0001);
    run(8'hd9, 8'h00, 0, 0, 0, 3, 3'h7);
    run(8'hdb, 8'h28, 0, 1, 0, 3, 3'h7);
    run(8'hdf, 8'h20, 0, 1, 0, 46, 3'h7);
    run(8'hdf, 8'h20, 0, 0, 0, 42, 3'h7);
    run(8'hdf, 8'h28, 0, 1, 0, 9, 3'h7);
    run(8'hdb, 8'h00, 0, 1, 0, 7, 3'h7);
    run(8'hdf, 8'h00, 0, 0, 0, 4, 3'h7);
  endtask : t_loads

  task automatic t_consts;
    fod_pkg::fod_const_type ek;
    for (int b = 8'he8; b <= 8'hee; b++) begin
      // expected constant selector for each second byte
      case (8'(b))
        8'he8: ek = fod_pkg::CK_ONE;
        8'he9: ek = fod_pkg::CK_L2T;
        8'hea: ek = fod_pkg::CK_L2E;
        8'heb: ek = fod_pkg::CK_PI;
        8'hec: ek = fod_pkg::CK_LG2;
        8'hed: ek = fod_pkg::CK_LN2;
        default: ek = fod_pkg::CK_ZERO;
      endcase
      run(8'hd9, 8'(b), 0, 0, 0, 5, 3'h7);
      chk({13'h0, ksel}, {13'h0, ek});
    end
    cw = 16'h1a5c;
    run(8'hd9, 8'h28, 0, 0, 0, 5, 3'h0);
    chk(ctrl, 16'h1a5c);
  endtask : t_consts

  task automatic t_arith;
    run(8'hdc, 8'hc9, 0, 1, 0, 10, 3'h0);
    chk({15'h0, dest}, 16'h0001);
    run(8'hd8, 8'hc9, 0, 0, 0, 5, 3'h0);
    chk({15'h0, dest}, 16'h0000);
    run(8'hdc, 8'h08, 0, 1, 0, 9, 3'h0);
    run(8'hd8, 8'h08, 0, 1, 0, 7, 3'h0);
    run(8'hde, 8'hca, 0, 0, 0, 5, 3'h1);
    chk({13'h0, idx}, 16'h0002);
    run(8'hda, 8'h08, 0, 1, 0, 12, 3'h0);
    run(8'hde, 8'h08, 0, 0, 0, 9, 3'h0);
    run(8'hd9, 8'hfd, 0, 0, 0, 8, 3'h0);
    run(8'hd9, 8'hfc, 0, 1, 0, 21, 3'h0);
    run(8'hd9, 8'hfa, 0, 0, 0, 60, 3'h0);
  endtask : t_arith

  task automatic t_trans;
    run(8'hd9, 8'hf3, 0, 1, 0, 162, 3'h1);
    run(8'hd9, 8'hf8, 0, 0, 0, 83, 3'h0);
    run(8'hd9, 8'hf5, 0, 1, 0, 92, 3'h0);
    run(8'hd9, 8'hf2, 0, 0, 0, 118, 3'h7);
    run(8'hd9, 8'hfe, 0, 1, 0, 141, 3'h0);
    run(8'hd9, 8'hfb, 0, 0, 0, 146, 3'h7);
  endtask : t_trans

  task automatic t_state;
    run(8'hdd, 8'h20, 0, 0, 0, 57, 3'h0);
    run(8'hdd, 8'h30, 0, 1, 0, 66, 3'h0);
    // three held cycles plus the edge that leaves the wait state
    run(8'hdd, 8'h30, 1, 0, 3, 62, 3'h0);
    run(8'hdd, 8'hd1, 0, 0, 0, 3, 3'h0);
    run(8'hdd, 8'h10, 0, 0, 0, 3, 3'h0);
    run(8'hd9, 8'h10, 0, 0, 0, 3, 3'h0);
  endtask : t_state

  // unknown opcode gives a one-cycle flag and stays ready
  task automatic t_illegal;
    u_pipe.issue(8'h00, 8'h00, 1'b0, 1'b0);
    chk({14'h0, illegal, ready}, 16'h0003);
    @(posedge clk);
    #1;
    chk({15'h0, illegal}, 16'h0000);
  endtask : t_illegal

  // ==========================================================
  // main sequence and hang guard
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk(ctrl, 16'h037f);
    chk({12'h0, ready, top}, 16'h0008);
    t_loads;
    t_consts;
    t_arith;
    t_trans;
    t_state;
    t_illegal;
    complete_run;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      complete_run;
    end
  end
endmodule : tb_top

`default_nettype wire
